// [timer16_consts.svh]
// byte offsets, pwm top values and divider taps of the 16-bit timer core
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

`define CAPTURE_LO_OFS   6'h26
`define CAPTURE_HI_OFS   6'h27
`define COMPARE_B_LO_OFS 6'h28
`define COMPARE_B_HI_OFS 6'h29
`define COMPARE_A_LO_OFS 6'h2a
`define COMPARE_A_HI_OFS 6'h2b
`define COUNTER_LO_OFS   6'h2c
`define COUNTER_HI_OFS   6'h2d

`define COUNTER_RST      16'h0000
`define COMPARE_RST      16'h0000
`define LATCH_RST        8'h00
`define COUNTER_MAX      16'hffff

`define TOP_8BIT         16'h00ff
`define TOP_9BIT         16'h01ff
`define TOP_10BIT        16'h03ff

`define DIV8_BITS        4'd3
`define DIV64_BITS       4'd6
`define DIV256_BITS      4'd8
`define DIV1024_BITS     4'd10

`endif

// [timer16_pkg.sv]
// types shared by the 16-bit timer core and its prescaler
package timer16_pkg;

   typedef enum logic [2:0] {
      CS_STOP     = 3'h0,
      CS_DIV1     = 3'h1,
      CS_DIV8     = 3'h2,
      CS_DIV64    = 3'h3,
      CS_DIV256   = 3'h4,
      CS_DIV1024  = 3'h5,
      CS_EXT_FALL = 3'h6,
      CS_EXT_RISE = 3'h7
   } clock_select_t;

   typedef enum logic [1:0] {
      PWM_OFF   = 2'h0,
      PWM_8BIT  = 2'h1,
      PWM_9BIT  = 2'h2,
      PWM_10BIT = 2'h3
   } pwm_mode_t;

   typedef enum {DIR_UP, DIR_DOWN} count_dir_t;

   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } io_req_t;

   typedef struct packed {
      logic compare_a;
      logic compare_b;
      logic overflow;
   } timer_events_t;

endpackage

// [timer16_prescaler.sv]
// timer tick source: cpu clock divider and synchronised external count pin
`timescale 1ns/100ps
`include "timer16_consts.svh"

module timer16_prescaler
   import timer16_pkg::*;
#(
   parameter int DIV_W = 10
) (
   input  wire logic          clk_i,
   input  wire logic          rst_n_i,
   input  wire clock_select_t clock_select_i,
   input  wire logic          external_count_pin_i,
   output logic               tick_o
);

   logic [DIV_W-1:0] div_r;
   logic [DIV_W-1:0] div_nxt;
   logic             pin_meta_r;
   logic             pin_sync_r;
   logic             pin_prev_r;
   logic             tick_r;
   logic             tick_nxt;
   logic             pin_rise;
   logic             pin_fall;

   function automatic logic low_ones(input logic [DIV_W-1:0] v, input logic [3:0] n);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < DIV_W; i++) begin
         if (i < int'(n) && !v[i]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // edges only seen from the second stage on; one cpu period minimum per level
   assign pin_rise = pin_sync_r & ~pin_prev_r;
   assign pin_fall = ~pin_sync_r & pin_prev_r;

   always_comb begin
      div_nxt  = div_r + 1'b1;
      tick_nxt = 1'b0;
      unique case (clock_select_i)
         CS_STOP:     tick_nxt = 1'b0;
         CS_DIV1:     tick_nxt = 1'b1;
         CS_DIV8:     tick_nxt = low_ones(div_r, `DIV8_BITS);
         CS_DIV64:    tick_nxt = low_ones(div_r, `DIV64_BITS);
         CS_DIV256:   tick_nxt = low_ones(div_r, `DIV256_BITS);
         CS_DIV1024:  tick_nxt = low_ones(div_r, `DIV1024_BITS);
         CS_EXT_FALL: tick_nxt = pin_fall;
         CS_EXT_RISE: tick_nxt = pin_rise;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_r      <= '0;
         pin_meta_r <= 1'b0;
         pin_sync_r <= 1'b0;
         pin_prev_r <= 1'b0;
         tick_r     <= 1'b0;
      end else begin
         div_r      <= div_nxt;
         pin_meta_r <= external_count_pin_i;
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
         tick_r     <= tick_nxt;
      end
   end

   assign tick_o = tick_r;

   chk_stop_no_tick: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clock_select_i == CS_STOP && $past(clock_select_i) == CS_STOP |-> !tick_r)
      else $error("tick while clock select is stop");

   chk_ext_rise_tick: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clock_select_i == CS_EXT_RISE && pin_rise |=> tick_r)
      else $error("rising pin edge not counted");

endmodule

// [timer16_core.sv]
// 16-bit timer core: counter, two compare registers and shared byte latch
`timescale 1ns/100ps
`include "timer16_consts.svh"

module timer16_core
   import timer16_pkg::*;
#(
   parameter int DIV_W = 10
) (
   input  wire logic          clk_i,
   input  wire logic          nrst_i,
   input  wire io_req_t       io_req_i,
   input  wire clock_select_t clock_select_i,
   input  wire logic          clear_on_match_a_i,
   input  wire pwm_mode_t     pwm_mode_i,
   input  wire logic          external_count_pin_i,
   input  wire logic [15:0]   capture_value_i,
   output logic [7:0]         io_rdata_o,
   output timer_events_t      events_o
);

   logic          rst_meta_r;
   logic          rst_n;
   logic          tick;

   logic [15:0]   counter_value_r;
   logic [15:0]   counter_value_nxt;
   logic [15:0]   compare_a_value_r;
   logic [15:0]   compare_a_value_nxt;
   logic [15:0]   compare_b_value_r;
   logic [15:0]   compare_b_value_nxt;
   logic [7:0]    latch_r;
   logic [7:0]    latch_nxt;
   logic [7:0]    rdata_r;
   logic [7:0]    rdata_nxt;
   count_dir_t    dir_r;
   count_dir_t    dir_nxt;
   logic          block_r;
   logic          block_nxt;
   logic          hit_a_prev_r;
   logic          hit_b_prev_r;
   timer_events_t events_r;
   timer_events_t events_nxt;

   logic          counter_load;
   logic [15:0]   load_value;
   logic          pwm_on;
   logic [15:0]   top;
   logic          hit_a;
   logic          hit_b;

   function automatic logic [15:0] pwm_top(input pwm_mode_t m);
      unique case (m)
         PWM_8BIT:  return `TOP_8BIT;
         PWM_9BIT:  return `TOP_9BIT;
         PWM_10BIT: return `TOP_10BIT;
         PWM_OFF:   return `COUNTER_MAX;
      endcase
   endfunction

   // unused high bits are forced to zero under pwm resolution
   function automatic logic [15:0] fit(input logic [15:0] v, input pwm_mode_t m);
      return v & pwm_top(m);
   endfunction

   // reset released through two flops; assertion stays asynchronous
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   timer16_prescaler #(
      .DIV_W(DIV_W)
   ) u_prescaler (
      .clk_i                (clk_i),
      .rst_n_i              (rst_n),
      .clock_select_i       (clock_select_i),
      .external_count_pin_i (external_count_pin_i),
      .tick_o               (tick)
   );

   assign pwm_on = (pwm_mode_i != PWM_OFF);
   assign top    = pwm_top(pwm_mode_i);

   // both compares run all the time; a fresh counter write masks them
   assign hit_a = (counter_value_r == compare_a_value_r) && !block_r;
   assign hit_b = (counter_value_r == compare_b_value_r) && !block_r;

   // cpu byte port: one latch serves counter, both compares and capture
   always_comb begin
      latch_nxt           = latch_r;
      rdata_nxt           = 8'h00;
      compare_a_value_nxt = compare_a_value_r;
      compare_b_value_nxt = compare_b_value_r;
      counter_load        = 1'b0;
      load_value          = {latch_r, io_req_i.wdata};
      if (io_req_i.wr) begin
         unique case (io_req_i.addr)
            `COUNTER_HI_OFS,
            `COMPARE_A_HI_OFS,
            `COMPARE_B_HI_OFS: latch_nxt = io_req_i.wdata;
            `COUNTER_LO_OFS:   counter_load = 1'b1;
            `COMPARE_A_LO_OFS:
               compare_a_value_nxt = fit({latch_r, io_req_i.wdata}, pwm_mode_i);
            `COMPARE_B_LO_OFS:
               compare_b_value_nxt = fit({latch_r, io_req_i.wdata}, pwm_mode_i);
            default: ;
         endcase
      end else if (io_req_i.rd) begin
         unique case (io_req_i.addr)
            `COUNTER_LO_OFS: begin
               rdata_nxt = counter_value_r[7:0];
               latch_nxt = counter_value_r[15:8];
            end
            `CAPTURE_LO_OFS: begin
               rdata_nxt = capture_value_i[7:0];
               latch_nxt = capture_value_i[15:8];
            end
            `COUNTER_HI_OFS,
            `CAPTURE_HI_OFS:   rdata_nxt = latch_r;
            `COMPARE_A_LO_OFS: rdata_nxt = compare_a_value_r[7:0];
            `COMPARE_A_HI_OFS: rdata_nxt = compare_a_value_r[15:8];
            `COMPARE_B_LO_OFS: rdata_nxt = compare_b_value_r[7:0];
            `COMPARE_B_HI_OFS: rdata_nxt = compare_b_value_r[15:8];
            default:           rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         latch_r           <= `LATCH_RST;
         rdata_r           <= 8'h00;
         compare_a_value_r <= `COMPARE_RST;
         compare_b_value_r <= `COMPARE_RST;
      end else begin
         latch_r           <= latch_nxt;
         rdata_r           <= rdata_nxt;
         compare_a_value_r <= compare_a_value_nxt;
         compare_b_value_r <= compare_b_value_nxt;
      end
   end

   // counter; a cpu load wins over a tick in the same cycle
   always_comb begin
      counter_value_nxt = counter_value_r;
      dir_nxt           = dir_r;
      block_nxt         = block_r;
      events_nxt        = '0;
      if (counter_load) begin
         counter_value_nxt = fit(load_value, pwm_mode_i);
         block_nxt         = 1'b1;
      end else if (tick) begin
         block_nxt = 1'b0;
         if (pwm_on) begin
            if (clear_on_match_a_i) begin
               dir_nxt = DIR_UP;
               if (counter_value_r >= top) begin
                  counter_value_nxt = 16'h0000;
                  events_nxt.overflow = 1'b1;
               end else begin
                  counter_value_nxt = counter_value_r + 16'h0001;
               end
            end else if (dir_r == DIR_UP) begin
               if (counter_value_r >= top) begin
                  dir_nxt           = DIR_DOWN;
                  counter_value_nxt = top - 16'h0001;
               end else begin
                  counter_value_nxt = counter_value_r + 16'h0001;
               end
            end else begin
               if (counter_value_r == 16'h0000) begin
                  dir_nxt             = DIR_UP;
                  counter_value_nxt   = 16'h0001;
                  events_nxt.overflow = 1'b1;
               end else begin
                  counter_value_nxt = counter_value_r - 16'h0001;
               end
            end
         end else if (clear_on_match_a_i && hit_a) begin
            counter_value_nxt = 16'h0000;
         end else begin
            counter_value_nxt   = counter_value_r + 16'h0001;
            events_nxt.overflow = (counter_value_r == `COUNTER_MAX);
         end
      end
      // a value held over many cpu cycles flags once, on arrival
      events_nxt.compare_a = hit_a && !hit_a_prev_r;
      events_nxt.compare_b = hit_b && !hit_b_prev_r;
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         counter_value_r <= `COUNTER_RST;
         dir_r           <= DIR_UP;
         block_r         <= 1'b0;
         hit_a_prev_r    <= 1'b0;
         hit_b_prev_r    <= 1'b0;
         events_r        <= '0;
      end else begin
         counter_value_r <= counter_value_nxt;
         dir_r           <= dir_nxt;
         block_r         <= block_nxt;
         hit_a_prev_r    <= hit_a;
         hit_b_prev_r    <= hit_b;
         events_r        <= events_nxt;
      end
   end

   assign io_rdata_o = rdata_r;
   assign events_o   = events_r;

   chk_clear_on_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      tick && !pwm_on && clear_on_match_a_i && !counter_load && !block_r
      && counter_value_r == compare_a_value_r |=> counter_value_r == 16'h0000)
      else $error("counter not cleared after compare A match");

   chk_free_count: assert property (@(posedge clk_i) disable iff (!rst_n)
      tick && !pwm_on && !clear_on_match_a_i && !counter_load
      |=> counter_value_r == $past(counter_value_r) + 16'h0001)
      else $error("counter did not increment");

   chk_hold_no_tick: assert property (@(posedge clk_i) disable iff (!rst_n)
      !tick && !counter_load |=> $stable(counter_value_r))
      else $error("counter moved without a tick");

   chk_pwm_wrap: assert property (@(posedge clk_i) disable iff (!rst_n)
      tick && pwm_on && clear_on_match_a_i && !counter_load && counter_value_r == top
      |=> counter_value_r == 16'h0000)
      else $error("pwm wrap mode did not return to zero at top");

   chk_pwm_turn: assert property (@(posedge clk_i) disable iff (!rst_n)
      tick && pwm_on && !clear_on_match_a_i && !counter_load && counter_value_r == top
      |=> dir_r == DIR_DOWN && counter_value_r == $past(top) - 16'h0001)
      else $error("pwm up/down mode did not turn at top");

   chk_high_latched: assert property (@(posedge clk_i) disable iff (!rst_n)
      io_req_i.wr && io_req_i.addr == `COUNTER_HI_OFS
      |=> latch_r == $past(io_req_i.wdata) && ($stable(counter_value_r[15:8]) || $past(tick)))
      else $error("counter high write not held in latch");

   chk_low_read: assert property (@(posedge clk_i) disable iff (!rst_n)
      !io_req_i.wr && io_req_i.rd && io_req_i.addr == `COUNTER_LO_OFS
      |=> latch_r == $past(counter_value_r[15:8]) && io_rdata_o == $past(counter_value_r[7:0]))
      else $error("counter low read did not fill latch");

   chk_load_resume: assert property (@(posedge clk_i) disable iff (!rst_n)
      counter_load && !pwm_on |=> counter_value_r == $past(load_value))
      else $error("counter load value not taken");

   chk_write_blocks: assert property (@(posedge clk_i) disable iff (!rst_n)
      counter_load |=> (!events_nxt.compare_a && !events_nxt.compare_b)
      ##1 ($past(tick) || !events_nxt.compare_a && !events_nxt.compare_b))
      else $error("compare event during blocked timer cycle");

   chk_flag_timing: assert property (@(posedge clk_i) disable iff (!rst_n)
      hit_a && !hit_a_prev_r |=> events_o.compare_a)
      else $error("compare A flag not one cycle after match");

   chk_compare_commit: assert property (@(posedge clk_i) disable iff (!rst_n)
      io_req_i.wr && io_req_i.addr == `COMPARE_B_LO_OFS && !pwm_on
      |=> compare_b_value_r == {$past(latch_r), $past(io_req_i.wdata)})
      else $error("compare B low write did not commit both bytes");

endmodule

// [cpu_port.sv]
// byte-wide cpu port model driving the timer request bus
`timescale 1ns/100ps
module cpu_port
   import timer16_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic [7:0] io_rdata_i,
   output io_req_t         io_req_o
);
   initial begin
      io_req_o = '0;
   end
   // one access per call, bus idle for a cycle after it
   task automatic access(input logic [5:0] a, input logic [7:0] d, input logic w,
                         output logic [7:0] q);
      @(negedge clk_i);
      io_req_o = '{addr: a, wdata: d, wr: w, rd: ~w};
      @(negedge clk_i);
      q = io_rdata_i;
      // idle bus shows a changed pattern, never the old request
      io_req_o = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask
   // pairs are never split by other traffic, so the shared latch stays intact
   task automatic write16(input logic [5:0] hi, input logic [15:0] v);
      logic [7:0] q;
      access(hi, v[15:8], 1'b1, q);
      access(hi - 6'h01, v[7:0], 1'b1, q);
   endtask
   task automatic read16(input logic [5:0] lo, output logic [15:0] v);
      logic [7:0] q;
      access(lo, 8'h00, 1'b0, q);
      v[7:0] = q;
      access(lo + 6'h01, 8'h00, 1'b0, q);
      v[15:8] = q;
   endtask
endmodule

// [sixteen_bit_timer_core_bench.sv]
// self-checking bench for the 16-bit timer core
`timescale 1ns/100ps
`include "timer16_consts.svh"
module sixteen_bit_timer_core_bench
   import timer16_pkg::*;
;
   logic          clk;
   logic          nrst;
   clock_select_t sel;
   logic          clr;
   pwm_mode_t     pwm;
   logic          pin;
   logic [15:0]   cap;
   io_req_t       req;
   logic [7:0]    rdata;
   timer_events_t ev;
   int            bad_count = 0;
   int            n_compared = 0;
   int            cnt_a = 0;
   int            cnt_b = 0;
   int            cnt_ov = 0;

   cpu_port host (.clk_i(clk), .io_rdata_i(rdata), .io_req_o(req));
   timer16_core #(.DIV_W(10)) DUT (
      .clk_i(clk), .nrst_i(nrst), .io_req_i(req), .clock_select_i(sel),
      .clear_on_match_a_i(clr), .pwm_mode_i(pwm), .external_count_pin_i(pin),
      .capture_value_i(cap), .io_rdata_o(rdata), .events_o(ev));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // counted on the rising edge so negedge readers never race it
   always @(posedge clk) begin
      cnt_a <= cnt_a + int'(ev.compare_a === 1'b1);
      cnt_b <= cnt_b + int'(ev.compare_b === 1'b1);
      cnt_ov <= cnt_ov + int'(ev.overflow === 1'b1);
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (bad_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk);
   endtask

   function automatic logic pulse(input int w);
      return w == 0 ? ev.compare_a : (w == 1 ? ev.compare_b : ev.overflow);
   endfunction

   // cycles between two successive pulses of one event
   task automatic period(input int w, output int n);
      int k;
      k = 0;
      while (pulse(w) !== 1'b1 && k < 5000) begin
         @(negedge clk);
         k++;
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (pulse(w) !== 1'b1 && n < 5000);
   endtask

   task automatic t_reset;
      logic [15:0] v;
      logic [7:0]  b;
      host.read16(`COUNTER_LO_OFS, v);
      check(v, 16'h0000);
      host.read16(`COMPARE_A_LO_OFS, v);
      check(v, 16'h0000);
      host.read16(`COMPARE_B_LO_OFS, v);
      check(v, 16'h0000);
      host.access(6'h10, 8'h00, 1'b0, b);
      check(b, 8'h00);
   endtask

   task automatic t_latch;
      logic [15:0] v;
      logic [7:0]  b;
      host.write16(`COUNTER_HI_OFS, 16'h12ff);
      host.read16(`COUNTER_LO_OFS, v);
      check(v, 16'h12ff);
      host.access(`COMPARE_A_HI_OFS, 8'hab, 1'b1, b);
      host.access(`COUNTER_LO_OFS, 8'h56, 1'b1, b);
      host.read16(`COUNTER_LO_OFS, v);
      check(v, 16'hab56);
      host.read16(`COMPARE_A_LO_OFS, v);
      check(v, 16'h0000);
      host.access(`COUNTER_LO_OFS, 8'h00, 1'b0, b);
      check(b, 8'h56);
      host.access(`COMPARE_B_HI_OFS, 8'h77, 1'b1, b);
      host.access(`COUNTER_HI_OFS, 8'h00, 1'b0, b);
      check(b, 8'h77);
      host.read16(`CAPTURE_LO_OFS, v);
      check(v, 16'hc3a5);
      host.write16(`COMPARE_A_HI_OFS, 16'h1234);
      host.write16(`COMPARE_B_HI_OFS, 16'hbeef);
      host.read16(`COMPARE_A_LO_OFS, v);
      check(v, 16'h1234);
      host.read16(`COMPARE_B_LO_OFS, v);
      check(v, 16'hbeef);
   endtask

   task automatic t_divide;
      int divs[5] = '{1, 8, 64, 256, 1024};
      int n;
      int o0;
      clr = 1'b1;
      host.write16(`COMPARE_B_HI_OFS, 16'h8000);
      host.write16(`COMPARE_A_HI_OFS, 16'h0003);
      host.write16(`COUNTER_HI_OFS, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         sel = clock_select_t'(i + 1);
         o0 = cnt_ov;
         period(0, n);
         period(0, n);
         check(n, 4 * divs[i]);
         check(cnt_ov - o0, 0);
      end
      sel = CS_STOP;
      // the pulse just seen is only counted at the next rising edge
      cycles(2);
      o0 = cnt_a;
      cycles(300);
      check(cnt_a - o0, 0);
   endtask

   task automatic t_no_clear;
      int a0;
      int o0;
      clr = 1'b0;
      host.write16(`COMPARE_A_HI_OFS, 16'hfff8);
      host.write16(`COUNTER_HI_OFS, 16'hfff0);
      a0 = cnt_a;
      o0 = cnt_ov;
      sel = CS_DIV1;
      cycles(30);
      sel = CS_STOP;
      check(cnt_a - a0, 1);
      check(cnt_ov - o0, 1);
   endtask

   task automatic t_block;
      int a0;
      int b0;
      host.write16(`COMPARE_B_HI_OFS, 16'h0006);
      host.write16(`COMPARE_A_HI_OFS, 16'h0005);
      a0 = cnt_a;
      b0 = cnt_b;
      // load onto the compare A value while stopped: no event may follow
      host.write16(`COUNTER_HI_OFS, 16'h0005);
      cycles(6);
      check(cnt_a - a0, 0);
      sel = CS_DIV1;
      cycles(6);
      check(cnt_b - b0, 1);
      host.write16(`COUNTER_HI_OFS, 16'h0005);
      cycles(20);
      sel = CS_STOP;
      check(cnt_a - a0, 0);
      check(cnt_b - b0, 2);
   endtask

   task automatic pin_pulse;
      pin = 1'b1;
      cycles(6);
      pin = 1'b0;
      cycles(6);
   endtask

   task automatic t_pin;
      int a0;
      for (int s = 6; s < 8; s++) begin
         sel = CS_STOP;
         host.write16(`COMPARE_A_HI_OFS, 16'h0003);
         host.write16(`COUNTER_HI_OFS, 16'h0000);
         sel = clock_select_t'(s);
         a0 = cnt_a;
         repeat (2) pin_pulse;
         check(cnt_a - a0, 0);
         pin = 1'b1;
         cycles(8);
         check(cnt_a - a0, s - 6);
         pin = 1'b0;
         cycles(8);
         check(cnt_a - a0, 1);
      end
      sel = CS_STOP;
   endtask

   task automatic t_pwm;
      int n;
      int top;
      host.write16(`COMPARE_A_HI_OFS, 16'h0010);
      for (int m = 1; m < 4; m++) begin
         pwm = pwm_mode_t'(m);
         top = (1 << (m + 7)) - 1;
         host.write16(`COUNTER_HI_OFS, 16'h0000);
         for (int c = 0; c < 2; c++) begin
            clr = c[0];
            sel = CS_DIV1;
            period(2, n);
            period(2, n);
            check(n, c ? top + 1 : 2 * top);
            sel = CS_STOP;
            cycles(1);
         end
      end
      pwm = PWM_OFF;
   endtask

   initial begin
      sel = CS_STOP;
      clr = 1'b0;
      pwm = PWM_OFF;
      pin = 1'b0;
      cap = 16'hc3a5;
      nrst = 1'b0;
      cycles(10);
      nrst = 1'b1;
      cycles(4);
      t_reset;
      t_latch;
      t_divide;
      t_no_clear;
      t_block;
      t_pin;
      t_pwm;
      wrap_up;
   end

   // run needs about 30k cycles; over three times that means a hang
   initial begin
      #800_000;
      bad_count++;
      wrap_up;
   end
endmodule
